// ---- common/epc_defines.svh ----
// timing and geometry constants for the byte-wide eeprom host controller
// assumes a 40 MHz clock (25 ns period)
`ifndef EPC_DEFINES_SVH
`define EPC_DEFINES_SVH

`define EPC_CLK_PERIOD_NS      25
`define EPC_ADDR_W             13
`define EPC_DATA_W             8
`define EPC_WRITE_CYCLE_MS     10
`define EPC_STROBE_HIGH_NS     200
`define EPC_PROTECT_REC_US     1
`define EPC_LOAD_WIN_MIN_US    1
`define EPC_LOAD_WIN_MAX_US    100
`define EPC_READ_CYCLE_NS      250
`define EPC_STROBE_LOW_NS      100
`define EPC_PROTECT_LEN        2'h3
`define EPC_POLL_BIT           7

`endif

// ---- common/epc_pkg.sv ----
// types for the eeprom host controller
// assumes epc_defines.svh on the include path
package epc_pkg;
  typedef enum logic [2:0] {
    EPC_IDLE,
    EPC_WR_LOW,
    EPC_WR_HIGH,
    EPC_RD_LOW,
    EPC_BUSY,
    EPC_POLL
  } epc_state_t;
endpackage

// ---- src/epc_timer.sv ----
// down-counting delay timer used for the strobe, read and poll pin timings of the controller
// assumes a load pulse and a preset count, counting on clk_i
`timescale 1ns/1ps
module epc_timer #(
  parameter int W = 20
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= count_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  // done depends on the count alone, so a reload on done forms no loop
  assign done_o = (cnt_q == '0);
endmodule

// ---- src/epc_host.sv ----
// host controller driving a byte-wide self-timed eeprom on its parallel pins
// assumes the eeprom pins are sampled synchronously to clk_i; data bus split in/out/enable
`timescale 1ns/1ps
`include "epc_defines.svh"

module epc_host
  import epc_pkg::*;
#(
  parameter int  CLK_NS      = `EPC_CLK_PERIOD_NS,
  parameter int  WRITE_CYC   = (`EPC_WRITE_CYCLE_MS * 1000000) / `EPC_CLK_PERIOD_NS,
  parameter int  WIN_MAX_CYC = (`EPC_LOAD_WIN_MAX_US * 1000) / `EPC_CLK_PERIOD_NS,
  parameter bit  USE_POLL    = 1'b1
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // user side
  input  wire logic                   req_i,
  input  wire logic                   req_we_i,
  input  wire logic                   req_last_i,
  input  wire logic                   req_protect_i,
  input  wire logic [`EPC_ADDR_W-1:0] req_addr_i,
  input  wire logic [`EPC_DATA_W-1:0] req_wdata_i,
  output logic                        req_ready_o,
  output logic                        rd_valid_o,
  output logic [`EPC_DATA_W-1:0]      rd_data_o,
  output logic                        wr_done_o,
  output logic                        wr_timeout_o,
  // eeprom pins
  output logic [`EPC_ADDR_W-1:0]      mem_addr_o,
  output logic                        mem_cs_n_o,
  output logic                        mem_oe_n_o,
  output logic                        mem_we_n_o,
  input  wire logic [`EPC_DATA_W-1:0] mem_data_i,
  output logic [`EPC_DATA_W-1:0]      mem_data_o,
  output logic                        mem_data_oe_o
);
  // ------------------------------------------------------------
  // timing counts
  // ------------------------------------------------------------
  localparam int TW = 20;
  localparam int LOW_CYC   = (`EPC_STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int HIGH_CYC  = (`EPC_STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROT_CYC  = (`EPC_PROTECT_REC_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int MIN_CYC   = (`EPC_LOAD_WIN_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC    = (`EPC_READ_CYCLE_NS + CLK_NS - 1) / CLK_NS;

  epc_state_t      state_q;
  logic            tmr_load;
  logic [TW-1:0]   tmr_cnt;
  logic            tmr_done;
  logic [1:0]      prot_cnt_q;
  logic            prot_rec_q;
  logic [TW-1:0]   win_q;
  logic [TW-1:0]   busy_q;
  logic [`EPC_DATA_W-1:0] wr_data_q;
  logic            last_q;
  logic            page_open_q;
  logic            accept;
  logic            spacing_ok;
  logic            poll_match;

  epc_timer #(
    .W (TW)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .load_i  (tmr_load),
    .count_i (tmr_cnt),
    .done_o  (tmr_done)
  );

  // ------------------------------------------------------------
  // request acceptance
  // ------------------------------------------------------------
  // lower bound of load spacing
  assign spacing_ok  = (win_q >= TW'(MIN_CYC)) || !req_we_i;
  assign req_ready_o = (state_q == EPC_IDLE) && tmr_done && spacing_ok;
  assign accept      = req_i && req_ready_o;
  // poll bit equals written data when done
  assign poll_match  = (mem_data_i[`EPC_POLL_BIT] == wr_data_q[`EPC_POLL_BIT]);

  always_comb begin
    tmr_load = 1'b0;
    tmr_cnt  = '0;
    if (accept) begin
      tmr_load = 1'b1;
      tmr_cnt  = req_we_i ? TW'(LOW_CYC) : TW'(RD_CYC);
    end else if (state_q == EPC_WR_LOW && tmr_done) begin
      tmr_load = 1'b1;
      tmr_cnt  = (prot_cnt_q == `EPC_PROTECT_LEN - 2'h1 && prot_rec_q) ? TW'(PROT_CYC) : TW'(HIGH_CYC);
    end else if (state_q == EPC_BUSY && tmr_done && USE_POLL) begin
      tmr_load = 1'b1;
      tmr_cnt  = TW'(RD_CYC);
    end else if (state_q == EPC_POLL && tmr_done) begin
      tmr_load = 1'b1;
      tmr_cnt  = TW'(HIGH_CYC);
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= EPC_IDLE;
    end else begin
      case (state_q)
        EPC_IDLE: begin
          if (accept) begin
            state_q <= req_we_i ? EPC_WR_LOW : EPC_RD_LOW;
          end else if (page_open_q && win_q >= TW'(WIN_MAX_CYC)) begin
            // load window expired, page write starts
            state_q <= EPC_BUSY;
          end
        end
        EPC_WR_LOW: begin
          if (tmr_done) begin
            state_q <= EPC_WR_HIGH;
          end
        end
        EPC_WR_HIGH: begin
          if (tmr_done) begin
            state_q <= last_q ? EPC_BUSY : EPC_IDLE;
          end
        end
        EPC_RD_LOW: begin
          if (tmr_done) begin
            state_q <= EPC_IDLE;
          end
        end
        EPC_BUSY: begin
          if (busy_q >= TW'(WRITE_CYC)) begin
            state_q <= EPC_IDLE;
          end else if (tmr_done && USE_POLL) begin
            state_q <= EPC_POLL;
          end
        end
        EPC_POLL: begin
          if (tmr_done) begin
            state_q <= (poll_match || busy_q >= TW'(WRITE_CYC)) ? EPC_IDLE : EPC_BUSY;
          end
        end
        default: state_q <= EPC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  // mode decode on control pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_cs_n_o    <= 1'b1;
      mem_oe_n_o    <= 1'b1;
      mem_we_n_o    <= 1'b1;
      mem_data_oe_o <= 1'b0;
    end else begin
      mem_cs_n_o    <= !(state_q == EPC_WR_LOW || state_q == EPC_RD_LOW || state_q == EPC_POLL || accept);
      // read-drive low only with strobe high
      mem_oe_n_o    <= !((accept && !req_we_i) || state_q == EPC_RD_LOW || state_q == EPC_POLL);
      mem_we_n_o    <= !((accept && req_we_i) || (state_q == EPC_WR_LOW && !tmr_done));
      mem_data_oe_o <= (accept && req_we_i) || state_q == EPC_WR_LOW;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_addr_o <= '0;
      mem_data_o <= '0;
      wr_data_q  <= '0;
      last_q     <= 1'b0;
      page_open_q <= 1'b0;
    end else if (accept) begin
      mem_addr_o <= req_addr_i;
      mem_data_o <= req_wdata_i;
      if (req_we_i) begin
        wr_data_q   <= req_wdata_i;
        last_q      <= req_last_i;
        page_open_q <= !req_last_i;
      end
    end else if (state_q == EPC_BUSY) begin
      last_q      <= 1'b0;
      page_open_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // protection sequence tracking
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prot_cnt_q <= '0;
      prot_rec_q <= 1'b0;
    end else if (accept && req_we_i) begin
      prot_rec_q <= req_protect_i;
      if (!req_protect_i) begin
        prot_cnt_q <= '0;
      end else if (prot_rec_q) begin
        prot_cnt_q <= prot_cnt_q + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // load window and write time counters
  // ------------------------------------------------------------
  // time since last byte load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      win_q <= TW'(MIN_CYC);
    end else if (accept && req_we_i) begin
      win_q <= '0;
    end else if (win_q != '1) begin
      win_q <= win_q + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_q <= '0;
    end else if (state_q != EPC_BUSY && state_q != EPC_POLL) begin
      busy_q <= '0;
    end else if (busy_q != '1) begin
      busy_q <= busy_q + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // user results
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_valid_o   <= 1'b0;
      rd_data_o    <= '0;
      wr_done_o    <= 1'b0;
      wr_timeout_o <= 1'b0;
    end else begin
      rd_valid_o   <= (state_q == EPC_RD_LOW) && tmr_done;
      if (state_q == EPC_RD_LOW && tmr_done) begin
        rd_data_o <= mem_data_i;
      end
      // pulses only on the edge that returns the sequencer to idle
      wr_done_o    <= ((state_q == EPC_BUSY) && busy_q >= TW'(WRITE_CYC)) ||
                      ((state_q == EPC_POLL) && tmr_done && (poll_match || busy_q >= TW'(WRITE_CYC)));
      wr_timeout_o <= ((state_q == EPC_BUSY) && busy_q >= TW'(WRITE_CYC)) ||
                      ((state_q == EPC_POLL) && tmr_done && !poll_match && busy_q >= TW'(WRITE_CYC));
    end
  end
endmodule

// ---- tb/epc_host_asserts.sv ----
// pin timing checker for the eeprom host controller
// assumes one clock domain, bound onto epc_host
`timescale 1ns/1ps
module epc_host_asserts #(
  parameter int WRITE_CYC = 2000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic mem_cs_n_o,
  input wire logic mem_oe_n_o,
  input wire logic mem_we_n_o,
  input wire logic mem_data_oe_o,
  input wire logic wr_timeout_o
);
  logic [23:0] gap_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------
  // strobe high run
  // ----------------
  always_ff @(posedge clk_i) begin
    // reset counts as a long idle, so the first load is not too close
    if (rst_i) gap_q <= 24'hFFFFFF;
    else if (!mem_we_n_o) gap_q <= 24'h000000;
    else if (gap_q != 24'hFFFFFF) gap_q <= gap_q + 24'h000001;
  end
  sequence s_rd_hold;
    (!mem_cs_n_o && !mem_oe_n_o && mem_we_n_o)[*8];
  endsequence
  AST_STROBE_HIGH: assert property ($rose(mem_we_n_o) |-> mem_we_n_o[*8])
    else $error("strobe high time too short");
  AST_LOAD_SPACE: assert property ($fell(mem_we_n_o) && $past(gap_q) != 24'h000000 |-> gap_q >= 24'h000024)
    else $error("byte loads too close");
  AST_WRITE_MODE: assert property (!mem_we_n_o |-> !mem_cs_n_o && mem_oe_n_o && mem_data_oe_o)
    else $error("write strobe in wrong mode");
  AST_READ_MODE: assert property (!mem_oe_n_o |-> mem_we_n_o && !mem_data_oe_o)
    else $error("read drive with bus driven");
  AST_READ_HOLD: assert property ($fell(mem_oe_n_o) |-> s_rd_hold)
    else $error("read cycle cut short");
  AST_FULL_WAIT: assert property (wr_timeout_o |-> int'(gap_q) >= WRITE_CYC - 16)
    else $error("write time ended early");
endmodule
bind epc_host epc_host_asserts #(.WRITE_CYC(WRITE_CYC)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .mem_cs_n_o(mem_cs_n_o), .mem_oe_n_o(mem_oe_n_o), .mem_we_n_o(mem_we_n_o),
  .mem_data_oe_o(mem_data_oe_o), .wr_timeout_o(wr_timeout_o));

// ---- tb/epc_eeprom_model.sv ----
// behavioural byte-wide eeprom with self-timed write
// assumes pins sampled on the host clock; busy length set by bench
`timescale 1ns/1ps
module epc_eeprom_model (
  input  wire logic        clk_i,
  input  wire logic [12:0] addr_i,
  input  wire logic        cs_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic [7:0]  data_i,
  input  wire logic [15:0] busy_cyc_i,
  output logic [7:0]       data_o
);
  logic [7:0]  mem [8192];
  logic [7:0]  last_q;
  logic [15:0] busy_q;
  initial begin
    busy_q = 16'h0000;
    last_q = 8'h00;
    data_o = 8'h00;
  end
  always @(posedge clk_i) begin
    if (!we_n_i && !cs_n_i && oe_n_i) begin
      mem[addr_i] <= data_i;
      last_q <= data_i;
      busy_q <= busy_cyc_i;
    end else if (busy_q != 16'h0000) busy_q <= busy_q - 16'h0001;
    if (!cs_n_i && !oe_n_i && we_n_i)
      data_o <= (busy_q != 16'h0000) ? {~last_q[7], last_q[6:0]} : mem[addr_i];
    else data_o <= ~data_o;
  end
endmodule

// ---- tb/eeprom_page_write_control_test.sv ----
// self-checking bench for the eeprom host controller
// assumes epc_host, the eeprom model and the bound checker
`timescale 1ns/1ps
module eeprom_page_write_control_test;
  logic        clk_i, rst_i, req_i, we_i, last_i, prot_i, rdy, rv, done, tmo, cs_n, oe_n, we_n, doe;
  logic [12:0] addr_i, maddr, base;
  logic [7:0]  wd_i, rd, mdo, dev_d;
  logic [15:0] busy;
  logic [7:0]  ref_mem [int];
  int          error_cnt, checked, cyc, cyc0, hi_run, run, i;
  integer      seed;
  wire  [7:0]  dq = doe ? mdo : dev_d;
  epc_host #(.WRITE_CYC(2000), .WIN_MAX_CYC(200)) uut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
    .req_we_i(we_i), .req_last_i(last_i), .req_protect_i(prot_i), .req_addr_i(addr_i), .req_wdata_i(wd_i),
    .req_ready_o(rdy), .rd_valid_o(rv), .rd_data_o(rd), .wr_done_o(done), .wr_timeout_o(tmo),
    .mem_addr_o(maddr), .mem_cs_n_o(cs_n), .mem_oe_n_o(oe_n), .mem_we_n_o(we_n), .mem_data_i(dq),
    .mem_data_o(mdo), .mem_data_oe_o(doe));
  epc_eeprom_model dev (.clk_i(clk_i), .addr_i(maddr), .cs_n_i(cs_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .data_i(dq), .busy_cyc_i(busy), .data_o(dev_d));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // ----------------
  // tasks
  // ----------------
  task automatic conclude();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("FAIL %0t %s", $time, m);
  endtask
  task automatic put(input logic w, l, p, input logic [12:0] a, input logic [7:0] d);
    int n;
    @(negedge clk_i);
    {req_i, we_i, last_i, prot_i, addr_i, wd_i} = {1'b1, w, l, p, a, d};
    n = 0;
    while (rdy !== 1'b1 && n < 5000) begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
    req_i = 1'b0;
    if (w) ref_mem[a] = d;
  endtask
  task automatic get(input logic [12:0] a);
    int n;
    put(1'b0, 1'b0, 1'b0, a, 8'h00);
    n = 0;
    while (rv !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    checked++;
    if (rv !== 1'b1 || rd !== ref_mem[a]) fail("read data");
  endtask
  task automatic wait_done(input logic exp_tmo);
    int n;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    checked++;
    if (done !== 1'b1 || tmo !== exp_tmo) fail("write end");
  endtask
  // ----------------
  // monitor and stimulus
  // ----------------
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      error_cnt++;
      conclude();
    end
    if (we_n) run <= run + 1;
    else begin
      if (run != 0) hi_run <= run;
      run <= 0;
    end
  end
  initial begin
    {rst_i, req_i, we_i, last_i, prot_i} = 5'h10;
    {addr_i, wd_i, busy} = {13'h0000, 8'h00, 16'h0258};
    {error_cnt, checked, cyc, run, hi_run, seed} = {32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hDDD7};
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    base = 13'($random(seed)) & 13'h1FC0;
    for (i = 0; i < 4; i++) put(1'b1, i == 3, 1'b0, base + 13'(i), 8'($random(seed)));
    wait_done(1'b0);
    for (i = 0; i < 4; i++) get(base + 13'(i));
    put(1'b1, 1'b0, 1'b1, 13'h1555, 8'hAA);
    put(1'b1, 1'b0, 1'b1, 13'h0AAA, 8'h55);
    put(1'b1, 1'b0, 1'b1, 13'h1555, 8'hA0);
    put(1'b1, 1'b1, 1'b0, base + 13'h0010, 8'h3C);
    wait_done(1'b0);
    checked++;
    if (hi_run < 40) fail("protect recovery");
    get(base + 13'h0010);
    // single load without last flag: page closes only when the load window runs out
    busy = 16'h0028;
    put(1'b1, 1'b0, 1'b0, base + 13'h0030, 8'hC3);
    cyc0 = cyc;
    wait_done(1'b0);
    checked++;
    if (cyc - cyc0 < 180) fail("page closed before load window");
    get(base + 13'h0030);
    busy = 16'h0A28;
    put(1'b1, 1'b1, 1'b0, base + 13'h0020, 8'h5A);
    wait_done(1'b1);
    repeat (700) @(negedge clk_i);
    get(base + 13'h0020);
    conclude();
  end
endmodule
